// ==== src/pdt_pkg.sv ====
package pdt_pkg;

  // Register indices; each register is one aligned APB word at four times its index
  localparam logic [7:0]  IDX_PRESCALER_VALUE  = 8'hd2;
  localparam logic [7:0]  IDX_COUNT_VALUE      = 8'hd3;
  localparam logic [7:0]  IDX_STATUS_CONTROL   = 8'hd4;
  localparam logic [7:0]  IDX_SLEEP_CONTROL    = 8'hd8;
  localparam logic [11:0] ADDR_PRESCALER_VALUE = {2'b00, IDX_PRESCALER_VALUE, 2'b00};
  localparam logic [11:0] ADDR_COUNT_VALUE     = {2'b00, IDX_COUNT_VALUE, 2'b00};
  localparam logic [11:0] ADDR_STATUS_CONTROL  = {2'b00, IDX_STATUS_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_SLEEP_CONTROL   = {2'b00, IDX_SLEEP_CONTROL, 2'b00};

  // Status/control field positions
  localparam int BIT_UNDERFLOW_FLAG  = 7;
  localparam int BIT_IRQ_ENABLE      = 6;
  localparam int BIT_RESERVED_ONE    = 5;
  localparam int BIT_RESERVED_ZERO   = 4;
  localparam int BIT_PRESCALER_RUN   = 3;
  localparam int DIVISION_SELECT_LSB = 0;
  localparam int DIVISION_SELECT_W   = 3;

  // Sleep control field positions
  localparam int BIT_LIGHT_SLEEP = 0;
  localparam int BIT_DEEP_SLEEP  = 1;

  // Reset and reload values
  localparam logic [6:0] PRESCALER_RELOAD = 7'h7f;
  localparam logic [7:0] COUNT_RELOAD     = 8'hff;
  localparam logic [7:0] STATUS_RESET     = 8'h00;

  // Core clock predivider
  localparam int PREDIVIDE       = 12;
  localparam int PREDIVIDE_W     = 4;

endpackage

// ==== src/pdt_predivider.sv ====
`timescale 1ns/1ps
// Produces a one-cycle tick every DIVIDE enabled core cycles
module pdt_predivider #(
  parameter int DIVIDE  = pdt_pkg::PREDIVIDE,
  parameter int WIDTH   = pdt_pkg::PREDIVIDE_W
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  input  wire logic clear,
  // Output
  output      logic tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } pdt_div_state_type;

  pdt_div_state_type state_reg;
  pdt_div_state_type state_next;

  localparam logic [WIDTH-1:0] LAST = WIDTH'(DIVIDE - 1);

  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.count = '0;
    end else if (enable) begin
      state_next.count = (state_reg.count == LAST) ? '0 : state_reg.count + 1'b1;
    end
  end

  assign tick = enable && !clear && (state_reg.count == LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// ==== src/pdt_tap_select.sv ====
`timescale 1ns/1ps
// Combinational pulse on each step that rolls over one selected prescaler tap
module pdt_tap_select #(
  parameter int TAPS = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     enable,
  input  wire logic [TAPS-2:0]          prescaler,
  input  wire logic [$clog2(TAPS)-1:0]  select,
  input  wire logic                     step,
  output      logic                     pulse
);

  typedef struct packed {
    logic dummy;
  } pdt_tap_state_type;

  logic [TAPS-1:0] fire;

  // Tap n fires when the prescaler's low n bits roll over, i.e. every 2^n steps
  genvar n;
  generate
    for (n = 0; n < TAPS; n++) begin : g_tap
      if (n == 0) begin : g_zero
        assign fire[n] = step;
      end else begin : g_more
        assign fire[n] = step && (prescaler[n-1:0] == '0);
      end
    end
  endgenerate

  assign pulse = enable && fire[select];

endmodule

// ==== src/pdt_timer.sv ====
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Prescaler steps once per twelve core clock cycles.
// - Prescaler reloads 7Fh after reaching zero, counting continuously.
// - Current prescaler count is readable.
// - Counter clock is prescaler tap selected by division select, factor 2^n.
// - Counter decrements on each selected tap, reloads FFh after zero.
// - Counter stays 8-bit for every division factor.
// - Software may read and write the counter while running.
// - Run bit clear freezes counter, holds prescaler at 7Fh.
// - With run bit set software may write prescaler 0..7Fh.
// - Reset sets counter FFh and prescaler 7Fh.
// - Decrement to zero sets underflow flag; flag and enable raise interrupt.
// - Writing 00h to counter or one to bit 7 sets flag.
// - Flag holds until software clears it.
// - Counter write beats simultaneous decrement to zero; no flag set.
// - Light sleep keeps timer running; underflow interrupt wakes device.
// - Deep sleep freezes prescaler, counter and status/control; sleep control still tracks.
// - Interrupt enable is bit 6, clear after reset.
// - Prescaler register bit 7 reads zero, bits 6..0 the count.
module pdt_timer (
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // Power state from the core
  input  wire logic        LIGHT_SLEEP,
  input  wire logic        DEEP_SLEEP,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  // Timer outputs
  output      logic        IRQ,
  output      logic        WAKEUP
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [6:0]  prescaler;
    logic [7:0]  count;
    logic        underflow_flag;
    logic        underflow_irq_enable;
    logic        reserved_one_bit;
    logic        reserved_zero_bit;
    logic        prescaler_run;
    logic [2:0]  division_select;
    logic        light_sync1;
    logic        light_sync2;
    logic        deep_sync1;
    logic        deep_sync2;
    logic [31:0] rdata;
  } pdt_state_type;

  pdt_state_type state_reg;
  pdt_state_type state_next;

  logic       step;
  logic       count_pulse;
  logic       frozen;
  logic       bus_access;
  logic       wr_access;
  logic       addr_ok;
  logic [11:0] byte_addr;

  // Sleep inputs come from another power controller, so synchronise them
  assign frozen = state_reg.deep_sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Clock chain

  pdt_predivider #(
    .DIVIDE (pdt_pkg::PREDIVIDE),
    .WIDTH  (pdt_pkg::PREDIVIDE_W)
  ) u_prediv (
    .clk    (MCLK),
    .rst    (RST),
    .enable (CE && !frozen && state_reg.prescaler_run),
    .clear  (CE && !state_reg.prescaler_run),
    .tick   (step)
  );

  pdt_tap_select #(
    .TAPS      (8)
  ) u_taps (
    .clk       (MCLK),
    .rst       (RST),
    .enable    (state_reg.prescaler_run),
    .prescaler (state_reg.prescaler),
    .select    (state_reg.division_select),
    .step      (step),
    .pulse     (count_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == pdt_pkg::ADDR_PRESCALER_VALUE) || (a == pdt_pkg::ADDR_COUNT_VALUE) ||
                (a == pdt_pkg::ADDR_STATUS_CONTROL) || (a == pdt_pkg::ADDR_SLEEP_CONTROL);
  endfunction

  assign byte_addr  = PADDR;
  assign addr_ok    = is_mapped(byte_addr);
  assign bus_access = PSEL && PENABLE;
  assign wr_access  = bus_access && PWRITE && PSTRB[0] && addr_ok && CE;

  // Zero-wait slave; unmapped addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = bus_access && !addr_ok;
  assign PRDATA  = state_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       count_write;
    logic       reaches_zero;
    logic [7:0] status_byte;
    count_write  = 1'b0;
    reaches_zero = 1'b0;
    status_byte  = 8'h00;
    state_next   = state_reg;

    // Two-flop synchronisers for the power-state inputs
    state_next.light_sync1 = LIGHT_SLEEP;
    state_next.light_sync2 = state_reg.light_sync1;
    state_next.deep_sync1  = DEEP_SLEEP;
    state_next.deep_sync2  = state_reg.deep_sync1;

    if (CE && !frozen) begin
      // Prescaler
      if (!state_reg.prescaler_run) begin
        state_next.prescaler = pdt_pkg::PRESCALER_RELOAD;
      end else if (step) begin
        if (state_reg.prescaler == 7'h00) begin
          state_next.prescaler = pdt_pkg::PRESCALER_RELOAD;
        end else begin
          state_next.prescaler = state_reg.prescaler - 7'h01;
        end
      end

      // Counter, frozen while the run bit is low
      if (count_pulse) begin
        if (state_reg.count == 8'h00) begin
          state_next.count = pdt_pkg::COUNT_RELOAD;
        end else begin
          state_next.count = state_reg.count - 8'h01;
          reaches_zero     = (state_reg.count == 8'h01);
        end
      end

      // Software writes; a counter write overrides the decrement
      if (wr_access) begin
        unique case (byte_addr)
          pdt_pkg::ADDR_PRESCALER_VALUE: begin
            if (state_reg.prescaler_run) begin
              state_next.prescaler = PWDATA[6:0];
            end
          end
          pdt_pkg::ADDR_COUNT_VALUE: begin
            count_write      = 1'b1;
            state_next.count = PWDATA[7:0];
          end
          pdt_pkg::ADDR_STATUS_CONTROL: begin
            // Writing zero to bit 7 clears the flag; a one sets it
            state_next.underflow_flag       = PWDATA[pdt_pkg::BIT_UNDERFLOW_FLAG];
            state_next.underflow_irq_enable = PWDATA[pdt_pkg::BIT_IRQ_ENABLE];
            state_next.reserved_one_bit     = PWDATA[pdt_pkg::BIT_RESERVED_ONE];
            state_next.reserved_zero_bit    = PWDATA[pdt_pkg::BIT_RESERVED_ZERO];
            state_next.prescaler_run        = PWDATA[pdt_pkg::BIT_PRESCALER_RUN];
            state_next.division_select      =
              PWDATA[pdt_pkg::DIVISION_SELECT_LSB +: pdt_pkg::DIVISION_SELECT_W];
          end
          default: begin
          end
        endcase
      end

      // Hardware set wins over a software clear in the same cycle
      if (reaches_zero && !count_write) begin
        state_next.underflow_flag = 1'b1;
      end
      if (count_write && PWDATA[7:0] == 8'h00) begin
        state_next.underflow_flag = 1'b1;
      end
    end

    // Read data is captured in the setup phase so it stands at the access phase
    status_byte = {state_reg.underflow_flag, state_reg.underflow_irq_enable,
                   state_reg.reserved_one_bit, state_reg.reserved_zero_bit,
                   state_reg.prescaler_run, state_reg.division_select};
    if (CE && PSEL && !PENABLE && !PWRITE) begin
      unique case (byte_addr)
        pdt_pkg::ADDR_PRESCALER_VALUE: state_next.rdata = {25'h0, state_reg.prescaler};
        pdt_pkg::ADDR_COUNT_VALUE:     state_next.rdata = {24'h0, state_reg.count};
        pdt_pkg::ADDR_STATUS_CONTROL:  state_next.rdata = {24'h0, status_byte};
        pdt_pkg::ADDR_SLEEP_CONTROL:   state_next.rdata = {30'h0, state_reg.deep_sync2,
                                                           state_reg.light_sync2};
        default:                       state_next.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg                      <= '0;
      state_reg.prescaler            <= pdt_pkg::PRESCALER_RELOAD;
      state_reg.count                <= pdt_pkg::COUNT_RELOAD;
      state_reg.underflow_irq_enable <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // Light sleep does not gate anything, so the interrupt doubles as a wake request
  assign IRQ    = state_reg.underflow_flag && state_reg.underflow_irq_enable;
  assign WAKEUP = IRQ && state_reg.light_sync2;

endmodule

// ==== test/pdt_timer_checker.sv ====
`timescale 1ns/1ps
module pdt_timer_checker (
  // Clock and power
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        LIGHT_SLEEP,
  input wire logic        DEEP_SLEEP,
  // Bus and outputs
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        IRQ,
  input wire logic        WAKEUP
);
  logic [2:0] ds_hist;
  logic [2:0] ls_hist;
  logic [1:0] stop_age;
  logic       acc;
  logic       wr4;
  assign acc = PSEL && PENABLE;
  // Deep sleep is synchronised, so only trust writes after three quiet cycles
  assign wr4 = acc && PWRITE && PSTRB[0] && CE && ds_hist == 3'h0
               && PADDR == pdt_pkg::ADDR_STATUS_CONTROL;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ds_hist <= 3'h7;
      ls_hist <= 3'h0;
      stop_age <= 2'h3;
    end else begin
      if (CE) begin
        ds_hist <= {ds_hist[1:0], DEEP_SLEEP};
        ls_hist <= {ls_hist[1:0], LIGHT_SLEEP};
      end
      if (wr4) begin
        stop_age <= PWDATA[3] ? 2'h0 : 2'h1;
      end else if (stop_age != 2'h0 && stop_age != 2'h3) begin
        stop_age <= stop_age + 2'h1;
      end
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  irq_set_a: assert property (wr4 && PWDATA[7:6] == 2'b11 |=> IRQ)
    else $error("interrupt missing after flag set");
  irq_mask_a: assert property (wr4 && !PWDATA[6] |=> !IRQ)
    else $error("interrupt while disabled");
  flag_hold_a: assert property ($fell(IRQ) |-> $past(wr4))
    else $error("interrupt dropped without status write");
  wake_gate_a: assert property (WAKEUP |-> IRQ)
    else $error("wake request without interrupt");
  wake_rise_a: assert property (IRQ && ls_hist == 3'h7 |-> WAKEUP)
    else $error("no wake request in light sleep");
  presc_bits_a: assert property (acc && !PWRITE && PADDR == pdt_pkg::ADDR_PRESCALER_VALUE
    |-> PRDATA[31:7] == 25'h0)
    else $error("prescaler read has stray bits");
  count_bits_a: assert property (acc && !PWRITE && PADDR == pdt_pkg::ADDR_COUNT_VALUE
    |-> PRDATA[31:8] == 24'h0)
    else $error("counter read wider than a byte");
  stop_presc_a: assert property (acc && !PWRITE && stop_age == 2'h3
    && PADDR == pdt_pkg::ADDR_PRESCALER_VALUE |-> PRDATA[7:0] == 8'h7f)
    else $error("stopped prescaler not at reload value");
endmodule
bind pdt_timer pdt_timer_checker pdt_timer_checker_i (.MCLK(MCLK), .RST(RST), .CE(CE),
  .LIGHT_SLEEP(LIGHT_SLEEP), .DEEP_SLEEP(DEEP_SLEEP), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
  .IRQ(IRQ), .WAKEUP(WAKEUP));

// ==== test/prescaled_8bit_downcounter_bench.sv ====
`timescale 1ns/1ps
module prescaled_8bit_downcounter_bench;
  localparam logic [11:0] PS = pdt_pkg::ADDR_PRESCALER_VALUE;
  localparam logic [11:0] CT = pdt_pkg::ADDR_COUNT_VALUE;
  localparam logic [11:0] SC = pdt_pkg::ADDR_STATUS_CONTROL;
  logic        MCLK, RST, CE, LIGHT_SLEEP, DEEP_SLEEP, PSEL, PENABLE, PWRITE;
  logic        PREADY, PSLVERR, IRQ, WAKEUP, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [3:0]  PSTRB;
  logic [2:0]  sel;
  logic [7:0]  v;
  int          err_count, compares, n;
  pdt_timer pdt_timer_i (.MCLK(MCLK), .RST(RST), .CE(CE), .LIGHT_SLEEP(LIGHT_SLEEP),
    .DEEP_SLEEP(DEEP_SLEEP), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .WAKEUP(WAKEUP));
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle edge after each transfer keeps strobes from being driven twice at one edge
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    // Only the watchdog ends a wait for the slave
    while (PREADY !== 1'b1) begin
      @(posedge MCLK);
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  function automatic int lo(input logic [2:0] s, input logic [7:0] c);
    return 12 * (int'(c) - 1) * (1 << s);
  endfunction
  function automatic int hi(input logic [2:0] s, input logic [7:0] c);
    return 12 * int'(c) * (1 << s) + 40;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {RST, CE, PSTRB} = 6'h3f;
    {LIGHT_SLEEP, DEEP_SLEEP, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    err_count = 0;
    compares = 0;
    void'($urandom(32'h7559));
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    apb(0, PS, 0); chk(r, 32'h7f);
    apb(0, CT, 0); chk(r, 32'hff);
    apb(0, SC, 0); chk(r, 32'h0);
    apb(0, 12'h354, 0); chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      sel = 3'($urandom_range(7, 0));
      v = 8'($urandom_range(3, 1));
      LIGHT_SLEEP <= 1'($urandom_range(1, 0));
      apb(1, SC, 8'h20);
      apb(1, CT, v);
      apb(1, SC, 8'h68 | sel);
      n = 0;
      while (IRQ !== 1'b1 && n < 6000) begin
        @(posedge MCLK);
        n++;
      end
      chk(32'(n >= lo(sel, v) && n <= hi(sel, v)), 32'h1);
      apb(0, SC, 0); chk(r, {24'h0, 8'he8 | sel});
    end
    apb(1, SC, 8'h60); apb(1, CT, 8'h00); chk({31'h0, IRQ}, 32'h1);
    apb(0, CT, 0); chk(r, 32'h0);
    apb(1, SC, 8'h60); chk({31'h0, IRQ}, 32'h0);
    apb(1, SC, 8'he0); chk({31'h0, IRQ}, 32'h1);
    apb(1, SC, 8'ha0); chk({31'h0, IRQ}, 32'h0);
    apb(0, SC, 0); chk(r, 32'ha0);
    apb(1, PS, 8'h33); apb(0, PS, 0); chk(r, 32'h7f);
    apb(1, SC, 8'h28); apb(1, PS, 8'h15); apb(0, PS, 0);
    chk(32'(r == 32'h15 || r == 32'h14), 32'h1);
    apb(1, PS, 8'h01);
    repeat (30) @(posedge MCLK);
    apb(0, PS, 0); chk(32'(r == 32'h7f || r == 32'h7e), 32'h1);
    DEEP_SLEEP <= 1'b1;
    repeat (4) @(posedge MCLK);
    apb(0, CT, 0);
    v = r[7:0];
    apb(1, CT, 8'h05);
    repeat (60) @(posedge MCLK);
    apb(0, CT, 0); chk(r, {24'h0, v});
    DEEP_SLEEP <= 1'b0;
    tally_and_finish;
  end
  initial begin
    #240000;
    err_count++;
    tally_and_finish;
  end
endmodule
